// *** pkg/cid_consts.svh ***
// constants for the identifier classifier: ids, field positions, timing
`ifndef CID_CONSTS_SVH
`define CID_CONSTS_SVH
`define CID_ID_W 11
`define CID_FC_HI 10
`define CID_FC_LO 7
`define CID_NODE_HI 6
`define CID_NMT_ID 11'h000
`define CID_SYNC_ID 11'h080
`define CID_FC_EMCY 4'h1
`define CID_FC_TPDO1 4'h3
`define CID_FC_RPDO1 4'h4
`define CID_FC_TPDO2 4'h5
`define CID_FC_RPDO2 4'h6
`define CID_FC_TPDO3 4'h7
`define CID_FC_RPDO3 4'h8
`define CID_FC_TPDO4 4'h9
`define CID_FC_RPDO4 4'ha
`define CID_FC_TSDO 4'hb
`define CID_FC_RSDO 4'hc
`define CID_FC_GUARD 4'he
`define CID_NODE_MIN 7'h01
`define CID_NODE_MAX 7'h7f
`define CID_SDO_RD 8'h40
`define CID_SDO_WR 8'h23
`define CID_SDO_RD_ACK 8'h43
`define CID_SDO_WR_ACK 8'h60
`define CID_GUARD_MS 100
`define CID_CLK_KHZ 25000
`define CID_GUARD_CYC (`CID_GUARD_MS * `CID_CLK_KHZ)
`endif

// *** pkg/cid_pkg.sv ***
// types shared by both ends of the identifier classifier
package cid_pkg;
  typedef enum logic [3:0] {
    CID_K_NONE, CID_K_NMT, CID_K_SYNC, CID_K_EMCY, CID_K_RPDO, CID_K_TPDO,
    CID_K_RSDO, CID_K_TSDO, CID_K_GUARD
  } cid_kind_t;
  typedef struct packed {
    logic [10:0] id;
    logic ext;
    logic [3:0] dlc;
    logic [63:0] data;
  } cid_frame_t;
  typedef logic [10:0] cid_id_t;
endpackage

// *** pkg/cid_link_if.sv ***
// frame link joining the network node and the master side
`timescale 1ns/1ps
interface cid_link_if;
  import cid_pkg::*;
  cid_frame_t m2n_frame;
  logic m2n_valid;
  logic m2n_ready;
  cid_frame_t n2m_frame;
  logic n2m_valid;
  logic n2m_ready;
  modport node (input m2n_frame, input m2n_valid, output m2n_ready,
                output n2m_frame, output n2m_valid, input n2m_ready);
  modport master (output m2n_frame, output m2n_valid, input m2n_ready,
                  input n2m_frame, input n2m_valid, output n2m_ready);
endinterface

// *** core/cid_skid.sv ***
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module cid_skid #(
  parameter int WIDTH = 80,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [$clog2(DEPTH)-1:0] wp_r, rp_r;
  logic [$clog2(DEPTH):0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != ($clog2(DEPTH)+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
    end
  end
  always_ff @(posedge mclk) begin
    if (push) mem_r[wp_r] <= in_data;
  end
endmodule

// *** core/cid_node.sv ***
// network node end: identifier split, classification, sdo server, emcy, guarding
`timescale 1ns/1ps
`include "cid_consts.svh"
module cid_node #(
  parameter int GUARD_CYC = `CID_GUARD_CYC,
  parameter int DICT_DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  cid_link_if.node link,
  input wire logic [6:0] node_addr,
  input wire logic id_load,
  input wire logic [3:0] id_sel,
  input wire cid_pkg::cid_id_t id_value,
  input wire logic err_event,
  input wire logic [15:0] err_code,
  input wire logic [31:0] tpdo_value,
  output cid_pkg::cid_kind_t rx_kind,
  output logic rx_strobe,
  output logic [31:0] rpdo_value,
  output logic [1:0] rpdo_num,
  output logic [7:0] nmt_state,
  output logic addr_ok
);
  import cid_pkg::*;

  // ==========================================
  // programmable identifier table
  // ==========================================
  // slot 0 emcy, 1..4 tpdo, 5..8 rpdo, 9 sdo tx, 10 sdo rx, 11 guard
  cid_id_t idt_r [12];
  logic [6:0] addr_r;
  wire addr_valid = (node_addr >= `CID_NODE_MIN) && (node_addr <= `CID_NODE_MAX);
  function automatic cid_id_t dflt(input logic [3:0] slot, input logic [6:0] a);
    logic [3:0] fc;
    fc = 4'h0;
    unique case (slot)
      4'h0: fc = `CID_FC_EMCY;
      4'h1: fc = `CID_FC_TPDO1;
      4'h2: fc = `CID_FC_TPDO2;
      4'h3: fc = `CID_FC_TPDO3;
      4'h4: fc = `CID_FC_TPDO4;
      4'h5: fc = `CID_FC_RPDO1;
      4'h6: fc = `CID_FC_RPDO2;
      4'h7: fc = `CID_FC_RPDO3;
      4'h8: fc = `CID_FC_RPDO4;
      4'h9: fc = `CID_FC_TSDO;
      4'ha: fc = `CID_FC_RSDO;
      default: fc = `CID_FC_GUARD;
    endcase
    return {fc, a};
  endfunction
  logic addr_seen_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_r <= 7'h00;
      addr_seen_r <= 1'b0;
    end else if (!addr_seen_r && addr_valid) begin
      addr_r <= node_addr;
      addr_seen_r <= 1'b1;
    end
  end
  // defaults follow the address once caught, then software may replace them
  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_idt
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) idt_r[g] <= 11'h000;
        else if (id_load && id_sel == 4'(g)) idt_r[g] <= id_value;
        else if (!addr_seen_r && addr_valid) idt_r[g] <= dflt(4'(g), node_addr);
      end
    end
  endgenerate

  // ==========================================
  // receive classification
  // ==========================================
  cid_frame_t rf;
  logic rq_valid, rq_ready;
  cid_skid #(.WIDTH($bits(cid_frame_t)), .DEPTH(2)) u_rxbuf (
    .mclk(mclk), .rst(rst),
    .in_data(link.m2n_frame), .in_valid(link.m2n_valid), .in_ready(link.m2n_ready),
    .out_data(rf), .out_valid(rq_valid), .out_ready(rq_ready)
  );
  wire [3:0] rx_fc = rf.id[`CID_FC_HI:`CID_FC_LO];
  wire [6:0] rx_nd = rf.id[`CID_NODE_HI:0];
  wire rx_std = !rf.ext;
  wire hit_nmt = rx_std && rf.id == `CID_NMT_ID;
  wire hit_sync = rx_std && rf.id == `CID_SYNC_ID;
  wire hit_sdo = rx_std && rf.id == idt_r[10];
  wire [1:0] rp_idx = (rf.id == idt_r[6]) ? 2'd1 : (rf.id == idt_r[7]) ? 2'd2 :
                      (rf.id == idt_r[8]) ? 2'd3 : 2'd0;
  wire hit_rpdo = rx_std && (rf.id == idt_r[5] || rf.id == idt_r[6] || rf.id == idt_r[7] || rf.id == idt_r[8]);
  wire nmt_mine = (rf.data[15:8] == 8'h00) || (rf.data[15:8] == {1'b0, addr_r});
  wire hit_any = addr_seen_r && (hit_nmt || hit_sync || hit_sdo || hit_rpdo);
  wire [7:0] sdo_cmd = rf.data[7:0];
  wire [15:0] sdo_idx = rf.data[23:8];
  wire [$clog2(DICT_DEPTH)-1:0] dsel = sdo_idx[$clog2(DICT_DEPTH)-1:0];
  wire operational = (nmt_state == 8'h05);

  // ==========================================
  // transmit arbitration
  // ==========================================
  typedef enum logic [1:0] {CID_S_IDLE, CID_S_SEND} cid_tx_st_t;
  cid_tx_st_t tx_st_r;
  logic tx_busy;
  logic emcy_pend_r, sync_pend_r, sdo_pend_r, guard_pend_r;
  logic [15:0] emcy_code_r;
  cid_frame_t sdo_resp_r, tx_frame_r;
  logic [31:0] dict_r [DICT_DEPTH];
  logic [$clog2(GUARD_CYC+1)-1:0] guard_cnt_r;
  logic toggle_r;
  assign tx_busy = (tx_st_r == CID_S_SEND);
  // sdo takes a request only when its answer slot is free: back-pressure
  assign rq_ready = !(hit_sdo && sdo_pend_r);
  wire take = rq_valid && rq_ready && hit_any;
  wire guard_tick = (guard_cnt_r == '0);
  wire load_tx = !tx_busy;
  wire pick_emcy = emcy_pend_r;
  wire pick_sync = !pick_emcy && sync_pend_r;
  wire pick_sdo = !pick_emcy && !pick_sync && sdo_pend_r;
  wire pick_guard = !pick_emcy && !pick_sync && !pick_sdo && guard_pend_r;
  wire pick_any = pick_emcy || pick_sync || pick_sdo || pick_guard;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nmt_state <= 8'h00;
      rx_kind <= CID_K_NONE;
      rx_strobe <= 1'b0;
      rpdo_value <= 32'h0;
      rpdo_num <= 2'd0;
      addr_ok <= 1'b0;
    end else begin
      addr_ok <= addr_seen_r;
      rx_strobe <= take;
      if (take) rx_kind <= hit_nmt ? CID_K_NMT : hit_sync ? CID_K_SYNC : hit_sdo ? CID_K_RSDO : CID_K_RPDO;
      if (!addr_seen_r && addr_valid) nmt_state <= 8'h7f;
      if (take && hit_nmt && nmt_mine) nmt_state <= rf.data[7:0];
      if (take && hit_rpdo && !hit_nmt && !hit_sync && !hit_sdo && operational) begin
        rpdo_value <= rf.data[31:0];
        rpdo_num <= rp_idx;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      emcy_pend_r <= 1'b0;
      sync_pend_r <= 1'b0;
      sdo_pend_r <= 1'b0;
      guard_pend_r <= 1'b0;
      emcy_code_r <= 16'h0;
      guard_cnt_r <= '0;
      toggle_r <= 1'b0;
      tx_st_r <= CID_S_IDLE;
      sdo_resp_r <= '0;
      tx_frame_r <= '0;
    end else begin
      guard_cnt_r <= guard_tick ? ($bits(guard_cnt_r))'(GUARD_CYC - 1) : guard_cnt_r - 1'b1;
      // set wins over the clear taken by the transmitter
      emcy_pend_r <= (emcy_pend_r && !(load_tx && pick_emcy)) || (err_event && addr_seen_r);
      if (err_event) emcy_code_r <= err_code;
      sync_pend_r <= (sync_pend_r && !(load_tx && pick_sync)) || (take && hit_sync && operational);
      guard_pend_r <= (guard_pend_r && !(load_tx && pick_guard)) || (guard_tick && addr_seen_r);
      if (take && hit_sdo && !hit_nmt && !hit_sync) begin
        sdo_pend_r <= 1'b1;
        sdo_resp_r.id <= idt_r[9];
        sdo_resp_r.ext <= 1'b0;
        sdo_resp_r.dlc <= 4'h8;
        sdo_resp_r.data[31:0] <= {rf.data[31:24], sdo_idx, (sdo_cmd == `CID_SDO_RD) ? `CID_SDO_RD_ACK : `CID_SDO_WR_ACK};
        sdo_resp_r.data[63:32] <= (sdo_cmd == `CID_SDO_RD) ? dict_r[dsel] : 32'h0;
      end else if (load_tx && pick_sdo) begin
        sdo_pend_r <= 1'b0;
      end
      unique case (tx_st_r)
        CID_S_IDLE: if (pick_any) begin
          tx_st_r <= CID_S_SEND;
          if (pick_emcy) tx_frame_r <= '{id: idt_r[0], ext: 1'b0, dlc: 4'h8, data: {48'h0, emcy_code_r}};
          else if (pick_sync) tx_frame_r <= '{id: idt_r[1], ext: 1'b0, dlc: 4'h4, data: {32'h0, tpdo_value}};
          else if (pick_sdo) tx_frame_r <= sdo_resp_r;
          else begin
            tx_frame_r <= '{id: idt_r[11], ext: 1'b0, dlc: 4'h1, data: {56'h0, toggle_r, nmt_state[6:0]}};
            toggle_r <= ~toggle_r;
          end
        end
        CID_S_SEND: if (link.n2m_ready) tx_st_r <= CID_S_IDLE;
      endcase
    end
  end

  // ==========================================
  // dictionary storage
  // ==========================================
  always_ff @(posedge mclk) begin
    if (take && hit_sdo && sdo_cmd == `CID_SDO_WR) dict_r[dsel] <= rf.data[63:32];
  end

  assign link.n2m_valid = tx_busy;
  assign link.n2m_frame = tx_frame_r;
endmodule

// *** core/cid_master.sv ***
// master end: issues nmt, sync and sdo frames and collects node frames
`timescale 1ns/1ps
`include "cid_consts.svh"
module cid_master (
  input wire logic mclk,
  input wire logic rst,
  cid_link_if.master link,
  input wire cid_pkg::cid_frame_t cmd_frame,
  input wire logic cmd_valid,
  output logic cmd_ready,
  output cid_pkg::cid_frame_t rsp_frame,
  output logic rsp_valid
);
  import cid_pkg::*;
  // ==========================================
  // one frame held until the node takes it
  // ==========================================
  cid_frame_t hold_r;
  logic hold_v_r;
  wire fire = hold_v_r && link.m2n_ready;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_r <= '0;
      hold_v_r <= 1'b0;
      cmd_ready <= 1'b1;
      rsp_frame <= '0;
      rsp_valid <= 1'b0;
    end else begin
      if (cmd_valid && cmd_ready) begin
        // format bit passed through so the node's own base-frame filter is exercised
        hold_r <= '{id: cmd_frame.id, ext: cmd_frame.ext, dlc: cmd_frame.dlc, data: cmd_frame.data};
        hold_v_r <= 1'b1;
        cmd_ready <= 1'b0;
      end else if (fire) begin
        hold_v_r <= 1'b0;
        cmd_ready <= 1'b1;
      end
      rsp_valid <= link.n2m_valid;
      if (link.n2m_valid) rsp_frame <= link.n2m_frame;
    end
  end
  assign link.m2n_frame = hold_r;
  assign link.m2n_valid = hold_v_r;
  assign link.n2m_ready = 1'b1;
endmodule

// *** verification/cid_link_monitor.sv ***
// link checker for the identifier classifier, watching the frame interface
`timescale 1ns/1ps
module cid_link_monitor #(
  parameter int NODE = 5
) (
  input wire logic mclk,
  input wire logic rst,
  input wire cid_pkg::cid_frame_t m2n_frame,
  input wire logic m2n_valid,
  input wire logic m2n_ready,
  input wire cid_pkg::cid_frame_t n2m_frame,
  input wire logic n2m_valid,
  input wire logic n2m_ready
);
  import cid_pkg::*;
  localparam logic [10:0] NID = 11'(NODE);
  // =========================================
  // decode
  wire logic [3:0] tx_fc = n2m_frame.id[10:7];
  wire logic sdo_req = m2n_valid && m2n_ready && !m2n_frame.ext && m2n_frame.id == (11'h600 | NID);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence req_s;
    sdo_req;
  endsequence
  // guard frames may win the link first, hence the wide window
  sequence reply_s;
    n2m_valid && n2m_frame.id == (11'h580 | NID);
  endsequence
  // =========================================
  // checks
  AST_BASE_ONLY: assert property (n2m_valid |-> !n2m_frame.ext)
    else $error("extended frame sent");
  AST_OWN_ADDR: assert property (n2m_valid |-> n2m_frame.id[6:0] == NID[6:0])
    else $error("node address field wrong");
  AST_FC_SET: assert property (n2m_valid |-> tx_fc inside {4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'hb, 4'he})
    else $error("function code not a transmit kind");
  AST_SDO_REPLY: assert property (req_s |-> ##[1:40] reply_s)
    else $error("sdo request unanswered");
  AST_REPLY_CODE: assert property (n2m_valid && tx_fc == 4'hb |-> n2m_frame.data[7:0] inside {8'h43, 8'h60})
    else $error("sdo reply code wrong");
  AST_REQ_HOLD: assert property (m2n_valid && !m2n_ready |=> m2n_valid && $stable(m2n_frame))
    else $error("request dropped before taken");
  AST_DLC_MAX: assert property (n2m_valid |-> n2m_frame.dlc <= 4'h8)
    else $error("data length over eight");
  AST_GUARD_LEN: assert property (n2m_valid && tx_fc == 4'he |-> n2m_frame.dlc == 4'h1)
    else $error("guard frame length wrong");
  AST_NO_COMMON: assert property (n2m_valid |-> n2m_frame.id != 11'h000 && n2m_frame.id != 11'h080)
    else $error("node sent a common id");
endmodule

// *** verification/test_canopen_cob_id_classifier.sv ***
// self-checking bench joining the node and master ends
`timescale 1ns/1ps
module test_canopen_cob_id_classifier;
  import cid_pkg::*;
  localparam int NODE = 5;
  localparam cid_id_t NID = 11'(NODE);
  logic mclk, rst, id_load, err_event, cmd_valid, cmd_ready, rx_strobe, rsp_valid, addr_ok;
  logic [6:0] node_addr;
  logic [3:0] id_sel;
  cid_id_t id_value;
  logic [15:0] err_code;
  logic [31:0] tpdo_value, rpdo_value, v;
  logic [1:0] rpdo_num;
  logic [7:0] nmt_state;
  cid_kind_t rx_kind, k;
  cid_frame_t cmd_frame, rsp_frame, f;
  cid_frame_t rq[$];
  int num_errors, n_checks, seed, guards;
  logic [31:0] dict_m [16];
  cid_link_if lnk();
  // short guard period keeps heartbeats inside the run
  cid_node #(.GUARD_CYC(50)) cid_node_i(.mclk(mclk), .rst(rst), .link(lnk.node), .node_addr(node_addr),
    .id_load(id_load), .id_sel(id_sel), .id_value(id_value), .err_event(err_event), .err_code(err_code),
    .tpdo_value(tpdo_value), .rx_kind(rx_kind), .rx_strobe(rx_strobe), .rpdo_value(rpdo_value),
    .rpdo_num(rpdo_num), .nmt_state(nmt_state), .addr_ok(addr_ok));
  cid_master cid_master_i(.mclk(mclk), .rst(rst), .link(lnk.master), .cmd_frame(cmd_frame),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_frame(rsp_frame), .rsp_valid(rsp_valid));
  cid_link_monitor #(.NODE(NODE)) mon(.mclk(mclk), .rst(rst), .m2n_frame(lnk.m2n_frame),
    .m2n_valid(lnk.m2n_valid), .m2n_ready(lnk.m2n_ready), .n2m_frame(lnk.n2m_frame),
    .n2m_valid(lnk.n2m_valid), .n2m_ready(lnk.n2m_ready));
  // =========================================
  // tasks
  // model identifier: function code in the top four bits, node address below
  function automatic cid_id_t cob(int fc);
    return 11'(fc * 128 + NODE);
  endfunction
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // request held until the edge at which ready is sampled high
  task automatic send(cid_id_t id, logic ext, logic [63:0] d, output cid_kind_t kd);
    int i = 0;
    @(posedge mclk);
    cmd_frame <= '{id: id, ext: ext, dlc: 4'h8, data: d};
    cmd_valid <= 1'b1;
    do begin
      @(posedge mclk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 50);
    cmd_valid <= 1'b0;
    chk("command taken", i < 50, 1);
    kd = CID_K_NONE;
    repeat (6) begin
      @(negedge mclk);
      if (rx_strobe === 1'b1) kd = rx_kind;
    end
  endtask
  task automatic get(output cid_frame_t fr);
    int i = 0;
    while (rq.size() == 0 && i < 60) begin
      @(negedge mclk);
      i++;
    end
    fr = '0;
    chk("response present", rq.size() != 0, 1);
    if (rq.size() != 0) fr = rq.pop_front();
  endtask
  // heartbeats arrive at any time, so they are counted apart from replies
  always @(posedge mclk) begin
    if (rsp_valid === 1'b1) begin
      if (rsp_frame.id === cob(14)) guards++;
      else rq.push_back(rsp_frame);
    end
  end
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    summarize();
  end
  // =========================================
  // scenarios
  initial begin
    rst = 1'b1; node_addr = NID[6:0]; id_load = 1'b0; id_sel = 4'h0; id_value = 11'h000;
    err_event = 1'b0; err_code = 16'h0000; tpdo_value = 32'h0; cmd_frame = '0; cmd_valid = 1'b0;
    seed = 32'ha6b4;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("addr_ok", addr_ok, 1);
    chk("nmt preop", nmt_state, 8'h7f);
    send(11'h000, 1'b0, 64'h05, k);
    chk("nmt kind", k, CID_K_NMT);
    chk("nmt state", nmt_state, 8'h05);
    for (int p = 0; p < 4; p++) begin
      v = $random(seed);
      send(11'(32'h200 + 256 * p + NODE), 1'b0, {32'h0, v}, k);
      chk("rpdo kind", k, CID_K_RPDO);
      chk("rpdo value", rpdo_value, v);
      chk("rpdo num", rpdo_num, p);
    end
    send(11'(32'h200 + NODE + 1), 1'b0, 64'h1, k);
    chk("other node", k, CID_K_NONE);
    send(11'h200 | NID, 1'b1, 64'h1, k);
    chk("extended", k, CID_K_NONE);
    chk("rpdo kept", rpdo_value, v);
    v = $random(seed);
    send(11'h600 | NID, 1'b0, {v, 8'h00, 16'h2003, 8'h23}, k);
    dict_m[32'h2003 % 16] = v;
    chk("sdo kind", k, CID_K_RSDO);
    get(f);
    chk("sdo wr id", f.id, cob(11));
    chk("sdo wr ack", f.data[7:0], 8'h60);
    send(11'h600 | NID, 1'b0, {32'h0, 8'h00, 16'h2003, 8'h40}, k);
    get(f);
    chk("sdo rd ack", f.data[7:0], 8'h43);
    chk("sdo rd index", f.data[23:8], 16'h2003);
    chk("sdo rd value", f.data[63:32], dict_m[32'h2003 % 16]);
    v = $random(seed);
    @(posedge mclk);
    err_code <= v[15:0];
    err_event <= 1'b1;
    @(posedge mclk);
    err_event <= 1'b0;
    get(f);
    chk("emcy id", f.id, cob(1));
    chk("emcy code", f.data[15:0], v[15:0]);
    v = $random(seed);
    @(posedge mclk);
    tpdo_value <= v;
    send(11'h080, 1'b0, 64'h0, k);
    chk("sync kind", k, CID_K_SYNC);
    get(f);
    chk("tpdo id", f.id, cob(3));
    chk("tpdo value", f.data[31:0], v);
    @(posedge mclk);
    id_sel <= 4'h5;
    id_value <= 11'h222;
    id_load <= 1'b1;
    @(posedge mclk);
    id_load <= 1'b0;
    v = $random(seed);
    send(11'h222, 1'b0, {32'h0, v}, k);
    chk("new id kind", k, CID_K_RPDO);
    chk("new id value", rpdo_value, v);
    send(11'h200 | NID, 1'b0, 64'h0, k);
    chk("old id", k, CID_K_NONE);
    chk("guards seen", guards > 0, 1);
    summarize();
  end
endmodule
